// ### core/mal_pkg.sv
// Purpose: Shared constants for the address-limit command block and its host end
// Assumes: Task-file fields are 8 bits, data words 16 bits
// Notes:   Both ends import this package
package mal_pkg;
  // ----------------------------------------------------------------
  // Command and feature codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_SET_MAX    = 8'hf9;
  localparam logic [7:0]  CMD_RD_NATIVE  = 8'hf8;
  localparam logic [7:0]  CMD_READ_SECT  = 8'h20;
  localparam logic [7:0]  FEAT_SET_PW    = 8'h01;
  localparam logic [7:0]  FEAT_LOCK      = 8'h02;
  localparam logic [7:0]  FEAT_UNLOCK    = 8'h03;
  localparam logic [7:0]  FEAT_FREEZE    = 8'h04;
  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int          SC_NV_BIT      = 0;
  localparam int          DH_LBA_BIT     = 6;
  localparam int          ST_RDY_BIT     = 6;
  localparam int          ST_DRQ_BIT     = 3;
  localparam int          ST_ERR_BIT     = 0;
  localparam int          ERR_ABORT_BIT  = 2;
  localparam logic [27:0] MAX_LBA28      = 28'hfffffff;
  localparam logic [7:0]  CHS_MAX_SECT   = 8'h3f;
  localparam logic [7:0]  SECTOR_LAST    = 8'hff;
  localparam logic [7:0]  PW_FIRST       = 8'h01;
  localparam logic [7:0]  PW_LAST        = 8'h10;
  localparam int          PW_WORDS       = 16;
  localparam logic [2:0]  UNLOCK_TRIES   = 3'h5;
  // ----------------------------------------------------------------
  // Host register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  HR_FEATURE     = 8'h00;
  localparam logic [7:0]  HR_SECT_CNT    = 8'h04;
  localparam logic [7:0]  HR_SECT_NUM    = 8'h08;
  localparam logic [7:0]  HR_CYL_LO      = 8'h0c;
  localparam logic [7:0]  HR_CYL_HI      = 8'h10;
  localparam logic [7:0]  HR_DEV_HEAD    = 8'h14;
  localparam logic [7:0]  HR_COMMAND     = 8'h18;
  localparam logic [7:0]  HR_STATUS      = 8'h1c;
  localparam logic [7:0]  HR_RESULT      = 8'h20;
  localparam logic [7:0]  HR_PW_BASE     = 8'h40;
  localparam logic [7:0]  HR_PW_END      = 8'h7c;
endpackage

// ### core/mal_if.sv
// Purpose: Task-file link between the host end and the device end
// Assumes: Single clock, both ends on clk_sys
// Notes:   No clocking block; the testbench joins the ends
`timescale 1ns/10ps
interface mal_if;
  logic        cmd_valid;
  logic [7:0]  feature;
  logic [7:0]  sect_cnt;
  logic [7:0]  sect_num;
  logic [7:0]  cyl_lo;
  logic [7:0]  cyl_hi;
  logic [7:0]  dev_head;
  logic [7:0]  command;
  logic        data_valid;
  logic [15:0] data_word;
  logic        busy;
  logic        drq;
  logic        done;
  logic [7:0]  status;
  logic [7:0]  error;
  logic [7:0]  res_sect_num;
  logic [7:0]  res_cyl_lo;
  logic [7:0]  res_cyl_hi;
  logic [7:0]  res_dev_head;
  modport dev (input cmd_valid, feature, sect_cnt, sect_num, cyl_lo, cyl_hi, dev_head,
               command, data_valid, data_word,
               output busy, drq, done, status, error, res_sect_num, res_cyl_lo,
               res_cyl_hi, res_dev_head);
  modport host (output cmd_valid, feature, sect_cnt, sect_num, cyl_lo, cyl_hi, dev_head,
                command, data_valid, data_word,
                input busy, drq, done, status, error, res_sect_num, res_cyl_lo,
                res_cyl_hi, res_dev_head);
endinterface

// ### core/mal_dev.sv
// Purpose: Device end of the maximum user address limit commands
// Assumes: resetn is the power-on reset; hw_reset_req is a one-cycle hardware reset
// Notes:   Nonvolatile limit lives in nv_max_ff, which only resetn reloads
// Functional notes
// [RL1] Opcode F9h selects limit-setting command
// [RL2] F9h sets limit only after native read
// [RL3] Otherwise feature 01-04 selects password functions
// [RL4] Replace limit; abort accesses beyond it
// [RL5] Identify words 61:60 report new limit
// [RL6] Second nonvolatile set aborts until reset
// [RL7] Locked or frozen state aborts limit set
// [RL8] Words 103:100 equal words 61:60; code holds the full limit in 103:100 and caps 61:60 at 28 bits
// [RL9] 28-bit max request selects native maximum
// [RL10] Extended protected area aborts limit set
// [RL11] Sector count bit 0 selects persistence
// [RL12] Host avoids nonvolatile set in offset mode
// [RL13] Host packs LBA across task-file fields
// [RL14] CHS mode takes cylinder number only
// [RL15] LBA result uses request bit layout
// [RL16] CHS result: sector 63, cylinder, head
// [RL17] Set password receives one data sector
// [RL18] Words 1-16 carry the 32-byte password
// [RL19] Password kept only until power cycle
// [RL20] Set password leaves device unlocked
// [RL21] Locked accepts only unlock and freeze
// [RL22] Five unlock tries, then unlock refused
// [RL23] Abort sets abort and error bits
//
// The register addresses and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module mal_dev
  import mal_pkg::*;
#(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_2000_0000,
  parameter logic [7:0]  HEADS      = 8'h10
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  mal_if.dev               bus,
  input  wire logic        hw_reset_req,
  input  wire logic        hpa_ext_set,
  output logic [31:0]      id_w61_60,
  output logic [47:0]      id_w103_100
);
  import mal_pkg::*;

  typedef enum logic [1:0] {DS_IDLE = 2'b01, DS_XFER = 2'b10} mal_dstate_t;
  typedef enum logic [2:0] {
    LK_UNLOCKED = 3'b001, LK_LOCKED = 3'b010, LK_FROZEN = 3'b100
  } mal_lock_t;

  mal_dstate_t st_ff;
  mal_lock_t   lock_ff;
  logic [7:0]  cnt_ff;
  logic        xfer_unlock_ff;
  logic        mism_ff;
  logic        prev_rnm_ff;
  logic [47:0] max_ff;
  logic [47:0] nv_max_ff;
  logic        nv_done_ff;
  logic [2:0]  tries_ff;
  logic [15:0] pw_ff [PW_WORDS];
  logic        done_ff;
  logic [7:0]  status_ff;
  logic [7:0]  error_ff;
  logic [31:0] res_ff;
  logic [31:0] id61_ff;

  // Pack a 28-bit address into {dev/head nibble, cyl high, cyl low, sector}
  function automatic logic [31:0] pack_lba(input logic [7:0] dh, input logic [47:0] a);
    logic [27:0] c;
    c = (a > 48'(MAX_LBA28)) ? MAX_LBA28 : a[27:0];
    return {dh[7:4], c};
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic        take;
  logic        is_lba;
  logic        nv_req;
  logic [27:0] req_lba;
  logic [47:0] chs_lba;
  logic [47:0] new_max;
  logic        set_max;
  logic        d_abort;
  logic        d_xfer;
  logic        pw_word;
  logic [3:0]  pw_idx;
  logic        word_bad;
  logic        fin;
  logic        fin_fail;

  assign take    = bus.cmd_valid && (st_ff == DS_IDLE);
  assign is_lba  = bus.dev_head[DH_LBA_BIT];
  assign nv_req  = bus.sect_cnt[SC_NV_BIT];                                          // RL11
  assign req_lba = {bus.dev_head[3:0], bus.cyl_hi, bus.cyl_lo, bus.sect_num};
  // Last sector of the requested cylinder; sector and head fields ignored
  assign chs_lba = 48'((48'({bus.cyl_hi, bus.cyl_lo}) + 48'h1) * 48'(HEADS)
                   * 48'(CHS_MAX_SECT)) - 48'h1;                                     // RL14
  assign set_max = (bus.command == CMD_SET_MAX) && prev_rnm_ff;                      // RL1 RL2

  // LBA 28-bit ceiling request maps to the whole native capacity when NATIVE_MAX lies above that ceiling
  always_comb begin
    if (!is_lba)
      new_max = chs_lba;
    else if (req_lba == MAX_LBA28 && NATIVE_MAX > 48'(MAX_LBA28))
      new_max = NATIVE_MAX;                                                          // RL9
    else
      new_max = 48'(req_lba);                                                        // RL13
  end

  // Accept or abort each command as it is taken
  always_comb begin
    d_abort = 1'b0;
    d_xfer  = 1'b0;
    if (set_max) begin
      d_abort = (lock_ff != LK_UNLOCKED)                                             // RL7
             || hpa_ext_set                                                          // RL10
             || (nv_req && nv_done_ff)                                               // RL6
             || (new_max > NATIVE_MAX);                                              // RL4
    end else if (bus.command == CMD_SET_MAX) begin                                   // RL3
      if (lock_ff == LK_FROZEN) begin
        d_abort = 1'b1;
      end else if (lock_ff == LK_LOCKED && bus.feature != FEAT_UNLOCK
                   && bus.feature != FEAT_FREEZE) begin
        d_abort = 1'b1;                                                              // RL21
      end else if (bus.feature == FEAT_SET_PW) begin
        d_xfer = 1'b1;                                                               // RL17
      end else if (bus.feature == FEAT_UNLOCK) begin
        d_abort = (tries_ff == 3'h0);                                                // RL22
        d_xfer  = (tries_ff != 3'h0);
      end else if (bus.feature != FEAT_LOCK && bus.feature != FEAT_FREEZE) begin
        d_abort = 1'b1;
      end
    end else if (bus.command == CMD_READ_SECT) begin
      d_abort = 48'(req_lba) > max_ff;                                               // RL4
    end else if (bus.command != CMD_RD_NATIVE) begin
      d_abort = 1'b1;
    end
  end

  // Password words sit in sector words 1..16; the rest are ignored
  assign pw_word  = (cnt_ff >= PW_FIRST) && (cnt_ff <= PW_LAST);                     // RL18
  assign pw_idx   = 4'(cnt_ff - PW_FIRST);
  assign word_bad = pw_word && (bus.data_word != pw_ff[pw_idx]);
  assign fin      = (st_ff == DS_XFER) && bus.data_valid && (cnt_ff == SECTOR_LAST);
  assign fin_fail = xfer_unlock_ff && (mism_ff || word_bad);

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Sector reception; a hardware reset drops a half-received sector
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_ff          <= DS_IDLE;
      cnt_ff         <= 8'h00;
      xfer_unlock_ff <= 1'b0;
      mism_ff        <= 1'b0;
    end else if (hw_reset_req) begin
      st_ff <= DS_IDLE;
    end else begin
      unique case (st_ff)
        DS_IDLE: begin
          cnt_ff         <= 8'h00;
          mism_ff        <= 1'b0;
          xfer_unlock_ff <= bus.feature == FEAT_UNLOCK;
          if (take && d_xfer)
            st_ff <= DS_XFER;                                                        // RL17
        end
        DS_XFER: begin
          if (bus.data_valid) begin
            cnt_ff  <= cnt_ff + 8'h01;
            mism_ff <= mism_ff || word_bad;
            if (fin)
              st_ff <= DS_IDLE;
          end
        end
      endcase
    end
  end

  // Remember whether the last command was the native maximum read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      prev_rnm_ff <= 1'b0;
    else if (hw_reset_req)
      prev_rnm_ff <= 1'b0;
    else if (take)
      prev_rnm_ff <= bus.command == CMD_RD_NATIVE;                                   // RL2
  end

  // ----------------------------------------------------------------
  // Limit and identify data
  // ----------------------------------------------------------------
  // Volatile limit falls back to the stored one on hardware reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      max_ff      <= NATIVE_MAX;
      nv_max_ff   <= NATIVE_MAX;
      nv_done_ff  <= 1'b0;
      id61_ff     <= 32'(MAX_LBA28);
      id_w103_100 <= NATIVE_MAX;
    end else if (hw_reset_req) begin
      max_ff      <= nv_max_ff;                                                      // RL11
      nv_done_ff  <= 1'b0;                                                           // RL6
      id61_ff     <= pack_lba(8'h00, nv_max_ff);
      id_w103_100 <= nv_max_ff;
    end else if (take && set_max && !d_abort) begin
      max_ff      <= new_max;                                                        // RL4
      id61_ff     <= pack_lba(8'h00, new_max);                                       // RL5 RL9
      id_w103_100 <= new_max;                                                        // RL8 RL9
      if (nv_req) begin
        nv_max_ff  <= new_max;                                                       // RL11
        nv_done_ff <= 1'b1;                                                          // RL6
      end
    end
  end
  assign id_w61_60 = id61_ff;

  // ----------------------------------------------------------------
  // Lock state, tries and password
  // ----------------------------------------------------------------
  // Lock state survives hardware reset; only power-on or a matching unlock clears it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lock_ff  <= LK_UNLOCKED;
      tries_ff <= UNLOCK_TRIES;
    end else if (hw_reset_req) begin
      tries_ff <= UNLOCK_TRIES;                                                      // RL22
    end else if (take && !set_max && !d_abort && bus.command == CMD_SET_MAX) begin
      if (bus.feature == FEAT_LOCK)
        lock_ff <= LK_LOCKED;                                                        // RL21
      else if (bus.feature == FEAT_FREEZE)
        lock_ff <= LK_FROZEN;                                                        // RL21
    end else if (fin) begin
      if (fin_fail)
        tries_ff <= tries_ff - 3'h1;                                                 // RL22
      else
        lock_ff <= LK_UNLOCKED;                                                      // RL20
    end
  end

  // Password is volatile: cleared by power-on only
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < PW_WORDS; i++)
        pw_ff[i] <= 16'h0000;                                                        // RL19
    end else if (st_ff == DS_XFER && bus.data_valid && !xfer_unlock_ff && pw_word) begin
      pw_ff[pw_idx] <= bus.data_word;                                                // RL18
    end
  end

  // ----------------------------------------------------------------
  // Completion and results
  // ----------------------------------------------------------------
  // Status and error stand until the next completion or sector request
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      done_ff   <= 1'b0;
      status_ff <= 8'h00;
      error_ff  <= 8'h00;
      res_ff    <= 32'h0000_0000;
    end else begin
      done_ff <= 1'b0;
      if (take && d_xfer) begin
        status_ff             <= 8'h00;
        status_ff[ST_RDY_BIT] <= 1'b1;
        status_ff[ST_DRQ_BIT] <= 1'b1;
      end else if ((take && !d_xfer) || fin) begin
        done_ff                  <= 1'b1;
        status_ff                <= 8'h00;                                           // RL23
        status_ff[ST_RDY_BIT]    <= 1'b1;
        status_ff[ST_ERR_BIT]    <= fin ? fin_fail : d_abort;                        // RL23
        error_ff                 <= 8'h00;
        error_ff[ERR_ABORT_BIT]  <= fin ? fin_fail : d_abort;                        // RL23
        if (take && bus.command == CMD_RD_NATIVE)
          res_ff <= pack_lba(bus.dev_head, NATIVE_MAX);
        else if (take && set_max && !d_abort && is_lba)
          res_ff <= pack_lba(bus.dev_head, new_max);                                 // RL15
        else if (take && set_max && !d_abort)
          res_ff <= {bus.dev_head[7:4], 4'(HEADS - 8'h01), bus.cyl_hi, bus.cyl_lo,
                     CHS_MAX_SECT};                                                  // RL16
      end
    end
  end

  assign bus.busy         = st_ff != DS_IDLE;
  assign bus.drq          = st_ff == DS_XFER;
  assign bus.done         = done_ff;
  assign bus.status       = status_ff;
  assign bus.error        = error_ff;
  assign bus.res_sect_num = res_ff[7:0];
  assign bus.res_cyl_lo   = res_ff[15:8];
  assign bus.res_cyl_hi   = res_ff[23:16];
  assign bus.res_dev_head = res_ff[31:24];
endmodule

// ### core/mal_host.sv
// Purpose: Host end issuing address-limit commands from a software register port
// Assumes: Software fills task-file and password registers before writing the command
// Notes:   Command writes while busy are ignored
`timescale 1ns/10ps
module mal_host
  import mal_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  mal_if.host              bus,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata
);
  import mal_pkg::*;

  typedef enum logic [2:0] {HS_IDLE = 3'b001, HS_WAIT = 3'b010, HS_SEND = 3'b100} mal_hstate_t;

  mal_hstate_t st_ff;
  logic [7:0]  tf_ff [7];
  logic [15:0] pw_ff [PW_WORDS];
  logic        cmd_ff;
  logic        dv_ff;
  logic [15:0] dw_ff;
  logic [7:0]  cnt_ff;
  logic [15:0] stat_ff;
  logic [31:0] res_ff;
  logic        launch;
  logic [2:0]  tf_idx;
  logic [3:0]  pw_sel;

  assign tf_idx = 3'(addr[7:2]);
  assign pw_sel = 4'(addr[7:2] - HR_PW_BASE[7:2]);
  assign launch = wr && addr == HR_COMMAND && st_ff == HS_IDLE && !bus.busy;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  // Task-file image; password words sit in the low half of each word
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 7; i++)
        tf_ff[i] <= 8'h00;
      for (int i = 0; i < PW_WORDS; i++)
        pw_ff[i] <= 16'h0000;
    end else if (wr && addr <= HR_COMMAND) begin
      if (addr != HR_COMMAND || launch)
        tf_ff[tf_idx] <= wdata[7:0];                                                 // RL13
    end else if (wr && addr >= HR_PW_BASE && addr <= HR_PW_END) begin
      pw_ff[pw_sel] <= wdata[15:0];                                                  // RL18
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      rdata <= 32'h0000_0000;
    else if (rd && addr <= HR_COMMAND)
      rdata <= {24'h000000, tf_ff[tf_idx]};
    else if (rd && addr == HR_STATUS)
      rdata <= {15'h0000, st_ff != HS_IDLE, stat_ff};
    else if (rd && addr == HR_RESULT)
      rdata <= res_ff;
    else
      rdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Command and data sequencing
  // ----------------------------------------------------------------
  // One command pulse, then a full sector whenever the device asks
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_ff   <= HS_IDLE;
      cmd_ff  <= 1'b0;
      dv_ff   <= 1'b0;
      dw_ff   <= 16'h0000;
      cnt_ff  <= 8'h00;
      stat_ff <= 16'h0000;
      res_ff  <= 32'h0000_0000;
    end else begin
      cmd_ff <= launch;                                                              // RL1
      dv_ff  <= 1'b0;
      unique case (st_ff)
        HS_IDLE: begin
          if (launch)
            st_ff <= HS_WAIT;
        end
        HS_WAIT: begin
          cnt_ff <= 8'h00;
          if (bus.done) begin
            st_ff   <= HS_IDLE;
            stat_ff <= {bus.error, bus.status};
            res_ff  <= {bus.res_dev_head, bus.res_cyl_hi, bus.res_cyl_lo, bus.res_sect_num};
          end else if (bus.drq && !cmd_ff && !dv_ff) begin // Starts only once no command pulse or data word is in flight
            st_ff <= HS_SEND;                                                        // RL17
          end
        end
        HS_SEND: begin
          dv_ff  <= 1'b1;
          cnt_ff <= cnt_ff + 8'h01;
          dw_ff  <= (cnt_ff >= PW_FIRST && cnt_ff <= PW_LAST) ?
                    pw_ff[4'(cnt_ff - PW_FIRST)] : 16'h0000;                         // RL18
          if (cnt_ff == SECTOR_LAST)
            st_ff <= HS_WAIT;
        end
      endcase
    end
  end

  assign bus.cmd_valid  = cmd_ff;
  assign bus.feature    = tf_ff[0];
  assign bus.sect_cnt   = tf_ff[1];
  assign bus.sect_num   = tf_ff[2];
  assign bus.cyl_lo     = tf_ff[3];
  assign bus.cyl_hi     = tf_ff[4];
  assign bus.dev_head   = tf_ff[5];
  assign bus.command    = tf_ff[6];
  assign bus.data_valid = dv_ff;
  assign bus.data_word  = dw_ff;
endmodule

// ### tb/mal_props.sv
// Purpose: Link-level checks between the host end and the device end
// Assumes: One clock; resetn is the power-on reset
// Notes:   Hardware reset is unseen here, so the native-read tracker may only over-report
`timescale 1ns/10ps
module mal_props
  import mal_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       cmd_valid,
  input wire logic [7:0] feature,
  input wire logic [7:0] command,
  input wire logic       busy,
  input wire logic       drq,
  input wire logic       done,
  input wire logic [7:0] status,
  input wire logic [7:0] error
);
  logic taken;
  logic ext_cmd;
  logic last_rd_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // --------------------------------------------------------------
  // Command tracking
  // --------------------------------------------------------------
  assign taken   = cmd_valid && !busy;
  assign ext_cmd = taken && command == CMD_SET_MAX && !last_rd_ff;
  // Remembers whether the last taken command was a native read
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      last_rd_ff <= 1'b0;
    end else if (taken) begin
      last_rd_ff <= command == CMD_RD_NATIVE;
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  property p_abort_code;
    done && error[ERR_ABORT_BIT] |-> status == 8'h41 && error == 8'h04;
  endproperty
  a_abort_code: assert property (p_abort_code)
    else $error("abort completion carries wrong status or error");
  property p_ok_code;
    done && !error[ERR_ABORT_BIT] |-> status == 8'h40 && error == 8'h00;
  endproperty
  a_ok_code: assert property (p_ok_code)
    else $error("good completion carries wrong status or error");
  property p_bad_feature;
    ext_cmd && !(feature inside {[FEAT_SET_PW:FEAT_FREEZE]}) |=> done && error[ERR_ABORT_BIT];
  endproperty
  a_bad_feature: assert property (p_bad_feature)
    else $error("unknown feature not aborted");
  property p_lock_nodata;
    ext_cmd && feature == FEAT_LOCK |=> done && !drq;
  endproperty
  a_lock_nodata: assert property (p_lock_nodata)
    else $error("lock did not finish at once");
  property p_setpw_data;
    ext_cmd && feature == FEAT_SET_PW |=> drq || (done && error[ERR_ABORT_BIT]);
  endproperty
  a_setpw_data: assert property (p_setpw_data)
    else $error("set password started no data phase");
  property p_native_done;
    taken && command == CMD_RD_NATIVE |=> done && status == 8'h40;
  endproperty
  a_native_done: assert property (p_native_done)
    else $error("native read did not complete");
  property p_drq_busy;
    drq |-> busy && status[ST_DRQ_BIT];
  endproperty
  a_drq_busy: assert property (p_drq_busy)
    else $error("data request without busy");
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("completion longer than one cycle");
endmodule

// ### tb/max_address_limit_command_tb_top.sv
// Purpose: Self-checking bench driving the host software port against the device end
// Assumes: Strobes one cycle, read data in the cycle after the read strobe
// Notes:   Completion is polled under a bounded loop
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module max_address_limit_command_tb_top;
  import mal_pkg::*;
  localparam logic [47:0] NMAX = 48'h0000_2000_0000;
  localparam logic [31:0] OK   = 32'h0000_0040;
  localparam logic [31:0] AB   = 32'h0000_0441;
  logic        clk_sys;
  logic        resetn;
  logic        hw_rst;
  logic        hpa;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [31:0] rdata;
  logic [31:0] id_lo;
  logic [47:0] id_hi;
  logic [31:0] got;
  int          fails;
  int          n_checks;
  mal_if link();
  mal_dev #(.NATIVE_MAX(NMAX)) mal_dev_inst(.clk_sys(clk_sys), .resetn(resetn), .bus(link),
    .hw_reset_req(hw_rst), .hpa_ext_set(hpa), .id_w61_60(id_lo), .id_w103_100(id_hi));
  mal_host mal_host_inst(.clk_sys(clk_sys), .resetn(resetn), .bus(link), .addr(addr),
    .wdata(wdata), .wr(sw_wr), .rd(sw_rd), .rdata(rdata));
  mal_props mal_props_inst(.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(link.cmd_valid),
    .feature(link.feature), .command(link.command), .busy(link.busy), .drq(link.drq),
    .done(link.done), .status(link.status), .error(link.error));
  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // --------------------------------------------------------------
  // Software port tasks
  // --------------------------------------------------------------
  task automatic complete_run;
    if (fails == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a; wdata <= d; sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a; sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Fills the task file, launches, then polls the host busy bit
  task automatic issue(input logic [7:0] f, input logic [7:0] sc, input logic [31:0] tf,
                       input logic [7:0] c, input logic [31:0] exp);
    int k;
    wr(HR_FEATURE, {24'h0, f});
    wr(HR_SECT_CNT, {24'h0, sc});
    for (int j = 0; j < 4; j++) wr(HR_SECT_NUM + 8'(4 * j), {24'h0, tf[8 * j +: 8]});
    wr(HR_COMMAND, {24'h0, c});
    for (k = 0; k < 400; k++) begin
      rd(HR_STATUS, got);
      if (got[16] === 1'b0) break;
    end
    if (k == 400) begin
      fails++;
      complete_run();
    end
    `CHK(got, exp)
  endtask
  // Limit set is only honoured straight after a native read
  task automatic setmax(input logic [7:0] sc, input logic [31:0] tf, input logic [31:0] exp);
    issue(8'h00, 8'h00, 32'h0, CMD_RD_NATIVE, OK);
    issue(8'h00, sc, tf, CMD_SET_MAX, exp);
  endtask
  task automatic pw(input logic [7:0] b);
    for (int i = 0; i < 16; i++) wr(HR_PW_BASE + 8'(4 * i), {24'h0, b + 8'(i)});
  endtask
  task automatic pulse;
    @(posedge clk_sys);
    hw_rst <= 1'b1;
    @(posedge clk_sys);
    hw_rst <= 1'b0;
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0; hw_rst = 1'b0; hpa = 1'b0; addr = 8'h00;
    wdata = 32'h0; sw_wr = 1'b0; sw_rd = 1'b0; fails = 0; n_checks = 0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    `CHK(id_lo, 32'h0fff_ffff)
    `CHK(id_hi, NMAX)
    issue(8'h07, 8'h00, 32'h0, CMD_SET_MAX, AB);
    setmax(8'h00, 32'h4012_3456, OK);
    rd(HR_RESULT, got);
    `CHK(got, 32'h4012_3456)
    `CHK(id_lo, 32'h0012_3456)
    `CHK(id_hi, 48'h0012_3456)
    issue(8'h00, 8'h00, 32'h4012_3457, CMD_READ_SECT, AB);
    issue(8'h00, 8'h00, 32'h4012_3456, CMD_READ_SECT, OK);
    setmax(8'h00, 32'h0500_0211, OK);
    rd(HR_RESULT, got);
    `CHK(got, 32'h0f00_023f)
    `CHK(id_lo, 32'h0000_0bcf)
    setmax(8'h00, 32'h4fff_ffff, OK);
    `CHK(id_lo, 32'h0fff_ffff)
    `CHK(id_hi, NMAX)
    @(posedge clk_sys) hpa <= 1'b1;
    setmax(8'h00, 32'h4000_0100, AB);
    @(posedge clk_sys) hpa <= 1'b0;
    setmax(8'h01, 32'h4000_1000, OK);
    setmax(8'h01, 32'h4000_2000, AB);
    pulse();
    setmax(8'h01, 32'h4000_2000, OK);
    pw(8'h30);
    issue(FEAT_SET_PW, 8'h00, 32'h0, CMD_SET_MAX, OK);
    issue(FEAT_LOCK, 8'h00, 32'h0, CMD_SET_MAX, OK);
    issue(FEAT_LOCK, 8'h00, 32'h0, CMD_SET_MAX, AB);
    setmax(8'h00, 32'h4000_0100, AB);
    pw(8'h50);
    for (int i = 0; i < 5; i++) issue(FEAT_UNLOCK, 8'h00, 32'h0, CMD_SET_MAX, AB);
    pw(8'h30);
    issue(FEAT_UNLOCK, 8'h00, 32'h0, CMD_SET_MAX, AB);
    pulse();
    issue(FEAT_UNLOCK, 8'h00, 32'h0, CMD_SET_MAX, OK);
    setmax(8'h00, 32'h4000_0100, OK);
    issue(FEAT_FREEZE, 8'h00, 32'h0, CMD_SET_MAX, OK);
    setmax(8'h00, 32'h4000_0200, AB);
    @(posedge clk_sys) resetn <= 1'b0;
    @(posedge clk_sys) resetn <= 1'b1;
    setmax(8'h00, 32'h4000_0200, OK);
    complete_run();
  end
endmodule
